/* design/ram_collision_pkg.sv */
// Shared widths, timing counts, carrier structs and state types for the
// two-port memory block with same-address collision handling.
// Assumes one 200 MHz system clock samples every memory-port signal.
package ram_collision_pkg;

	// Widths of one memory word and its address.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W  = 4;

	// System clock period in nanoseconds.
	localparam real CLK_PERIOD_NS = 5.0;

	// Port timing figures in nanoseconds.
	localparam real NEW_DO_ACCESS_NS    = 7.5;
	localparam real STROBE_ACCESS_NS    = 7.5;
	localparam real WRITE_UPDATE_NS     = 3.0;
	localparam real COLLIDE_HOLD_NS     = 7.0;
	localparam real EDGE_SETUP_NS       = 5.0;
	localparam real EDGE_HOLD_NS        = 5.0;

	// A least time rounds up, never below one cycle.
	function automatic int cyc_min(real t);
		int c;
		c = int'($ceil(t / CLK_PERIOD_NS));
		return (c < 1) ? 1 : c;
	endfunction : cyc_min

	// A longest time rounds down, never below one cycle.
	function automatic int cyc_max(real t);
		int c;
		c = int'($floor(t / CLK_PERIOD_NS));
		return (c < 1) ? 1 : c;
	endfunction : cyc_max

	localparam logic [CNT_W-1:0] SYNC_ACCESS_CYC =
		CNT_W'(cyc_min(NEW_DO_ACCESS_NS));
	localparam logic [CNT_W-1:0] PIPE_EXTRA_CYC = 4'h1;
	localparam logic [CNT_W-1:0] STROBE_ACCESS_CYC =
		CNT_W'(cyc_min(STROBE_ACCESS_NS));
	localparam logic [CNT_W-1:0] WRITE_UPDATE_CYC =
		CNT_W'(cyc_min(WRITE_UPDATE_NS));
	localparam logic [CNT_W-1:0] COLLIDE_HOLD_CYC =
		CNT_W'(cyc_max(COLLIDE_HOLD_NS));
	localparam logic [CNT_W-1:0] READ_AFTER_WRITE_EDGE_SETUP_CYC =
		CNT_W'(cyc_min(EDGE_SETUP_NS));
	localparam logic [CNT_W-1:0] READ_AFTER_WRITE_EDGE_HOLD_CYC =
		CNT_W'(cyc_min(EDGE_HOLD_NS));
	localparam logic [CNT_W-1:0] LAST_CYC = 4'h1;

	// Resting levels of the port clocks and the active-low strobes.
	localparam logic CLOCK_IDLE  = 1'h0;
	localparam logic STROBE_IDLE = 1'h1;

	typedef struct packed {
		logic              write_port_clock;
		logic              write_enable_n;
		logic              write_block_select_n;
		logic              async_write_strobe_n;
		logic [ADDR_W-1:0] write_address;
		logic [DATA_W-1:0] write_data_in;
		logic              write_parity_in;
	} write_port_t;

	typedef struct packed {
		logic              read_port_clock;
		logic              async_read_strobe_n;
		logic [ADDR_W-1:0] read_address;
	} read_port_t;

	typedef struct packed {
		logic write_async;
		logic read_async;
		logic read_pipelined;
		logic parity_generation_enable;
	} port_mode_t;

	typedef enum logic {RD_IDLE, RD_ACCESS} rd_state_t;

endpackage : ram_collision_pkg

/* design/signal_edge.sv */
// Edge finder for one port signal sampled on the system clock.
// Assumes the signal is already synchronous to ref_clk.
`timescale 1ns/1ps
module signal_edge
	import ram_collision_pkg::*;
#(
	parameter logic IDLE = 1'h1
) (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	// Watched signal
	input  wire logic sig,
	// Edges seen this cycle
	output logic      rise,
	output logic      fall
);

	logic prev;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			prev <= IDLE;
		end else begin
			prev <= sig;
		end
	end

	assign rise = sig & ~prev;
	assign fall = ~sig & prev;

endmodule : signal_edge

/* design/two_port_ram.sv */
// Two-port memory block with a write port and a read port, each either
// clocked by its own port clock or timed by an active-low strobe.
// Assumes all port signals are synchronous to ref_clk and that the port
// clocks run well below ref_clk, so each edge is seen as one cycle.
`timescale 1ns/1ps
module two_port_ram
	import ram_collision_pkg::*;
#(
	parameter int DEPTH = 256
) (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              sys_rst,
	// Port configuration
	input  wire port_mode_t        mode,
	// Write port
	input  wire write_port_t       wr,
	// Read port
	input  wire read_port_t        rd,
	// Read results and write-side parity check
	output logic [DATA_W-1:0]      read_data,
	output logic                   read_parity,
	output logic                   write_parity_error
);

	// Upper bound of the strobed access check, kept an int for the range.
	localparam int STROBE_ACC = int'(STROBE_ACCESS_CYC);

	logic [DATA_W-1:0] mem        [DEPTH];
	logic              mem_parity [DEPTH];

	logic wclk_rise;
	logic wclk_fall;
	logic rclk_rise;
	logic wstb_fall;
	logic rstb_fall;
	logic rstb_rise;

	signal_edge #(.IDLE(CLOCK_IDLE)) u_wclk (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.sig     (wr.write_port_clock),
		.rise    (wclk_rise),
		.fall    (wclk_fall)
	);

	signal_edge #(.IDLE(CLOCK_IDLE)) u_rclk (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.sig     (rd.read_port_clock),
		.rise    (rclk_rise),
		.fall    ()
	);

	signal_edge #(.IDLE(STROBE_IDLE)) u_wstb (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.sig     (wr.async_write_strobe_n),
		.rise    (),
		.fall    (wstb_fall)
	);

	signal_edge #(.IDLE(STROBE_IDLE)) u_rstb (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.sig     (rd.async_read_strobe_n),
		.rise    (rstb_rise),
		.fall    (rstb_fall)
	);

	// Write events.
	logic              sync_wr;
	logic              async_wr;
	logic              wr_fire;
	logic              wr_parity;
	logic [DATA_W-1:0] lookup;
	logic              lookup_parity;
	logic              same_addr;

	assign sync_wr = ~mode.write_async & wclk_rise & ~wr.write_enable_n
		& ~wr.write_block_select_n;
	assign async_wr = mode.write_async & wstb_fall
		& ~wr.write_block_select_n;
	assign wr_fire = sync_wr | async_wr;
	assign wr_parity = mode.parity_generation_enable
		? ^wr.write_data_in : wr.write_parity_in;
	assign same_addr = wr_fire & (wr.write_address == rd.read_address);

	// A write landing in the read's own cycle is forwarded, so the read
	// sees the new word whether the write came by clock or by strobe.
	assign lookup = same_addr ? wr.write_data_in
		: mem[rd.read_address];
	assign lookup_parity = same_addr ? wr_parity
		: mem_parity[rd.read_address];

	// The array has no reset; its contents are undefined until written.
	always_ff @(posedge ref_clk) begin
		if (wr_fire) begin
			mem[wr.write_address]        <= wr.write_data_in;
			mem_parity[wr.write_address] <= wr_parity;
		end
	end

	// The flag is only meaningful with external parity; while parity is
	// generated each clocked write clears it, but user logic must ignore it anyway.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			write_parity_error <= 1'h0;
		end else if (sync_wr) begin
			write_parity_error <= ~mode.parity_generation_enable
				& (^wr.write_data_in != wr.write_parity_in);
		end
	end

	// Windows after the write clock edges in which a strobed read is unsafe.
	logic [CNT_W-1:0]  raw_setup_cnt;
	logic [CNT_W-1:0]  raw_hold_cnt;
	logic [ADDR_W-1:0] raw_addr;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			raw_setup_cnt <= '0;
			raw_hold_cnt  <= '0;
			raw_addr      <= '0;
		end else begin
			if (sync_wr) begin
				raw_setup_cnt <= READ_AFTER_WRITE_EDGE_SETUP_CYC;
				raw_addr      <= wr.write_address;
			end else if (raw_setup_cnt != '0) begin
				raw_setup_cnt <= raw_setup_cnt - LAST_CYC;
			end
			if (~mode.write_async & wclk_fall) begin
				raw_hold_cnt <= READ_AFTER_WRITE_EDGE_HOLD_CYC;
			end else if (raw_hold_cnt != '0) begin
				raw_hold_cnt <= raw_hold_cnt - LAST_CYC;
			end
		end
	end

	// Read control.
	rd_state_t         rd_state;
	logic [CNT_W-1:0]  rd_cnt;
	logic [CNT_W-1:0]  hold_cnt;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_value;
	logic              rd_value_parity;
	logic              poison;
	logic              rstb_low;
	logic              start_sync;
	logic              start_async;
	logic              refresh;
	logic              newer_lost;
	logic              stale;
	logic              collide_late;
	logic              rd_present;
	logic [CNT_W-1:0]  sync_cnt;

	assign rstb_low = ~rd.async_read_strobe_n;
	assign start_sync = ~mode.read_async & rclk_rise;
	assign start_async = mode.read_async & (rstb_fall
		| (rstb_low & (rd.read_address != rd_addr)));
	assign refresh = mode.read_async & rstb_low & wr_fire
		& (wr.write_address == rd_addr);
	assign stale = (raw_setup_cnt != '0)
		& (raw_addr == rd.read_address);
	assign newer_lost = mode.read_async & rstb_rise
		& (raw_hold_cnt != '0);
	assign collide_late = ~mode.read_async & (rd_state == RD_ACCESS)
		& (hold_cnt != '0) & async_wr & (wr.write_address == rd_addr);
	// Pipelined output adds one register stage to the access time.
	assign sync_cnt = mode.read_pipelined
		? SYNC_ACCESS_CYC + PIPE_EXTRA_CYC : SYNC_ACCESS_CYC;
	assign rd_present = (rd_state == RD_ACCESS) & (rd_cnt == LAST_CYC);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_state        <= RD_IDLE;
			rd_cnt          <= '0;
			hold_cnt        <= '0;
			rd_addr         <= '0;
			rd_value        <= '0;
			rd_value_parity <= 1'h0;
			poison          <= 1'h0;
		end else if (start_sync) begin
			rd_state        <= RD_ACCESS;
			rd_cnt          <= sync_cnt;
			hold_cnt        <= COLLIDE_HOLD_CYC;
			rd_addr         <= rd.read_address;
			rd_value        <= lookup;
			rd_value_parity <= lookup_parity;
			poison          <= 1'h0;
		end else if (start_async) begin
			rd_state        <= RD_ACCESS;
			rd_cnt          <= STROBE_ACCESS_CYC;
			hold_cnt        <= '0;
			rd_addr         <= rd.read_address;
			rd_value        <= lookup;
			rd_value_parity <= lookup_parity;
			poison          <= stale;
		end else if (refresh) begin
			rd_state        <= RD_ACCESS;
			rd_cnt          <= WRITE_UPDATE_CYC;
			rd_value        <= wr.write_data_in;
			rd_value_parity <= wr_parity;
		end else if (newer_lost) begin
			rd_state <= RD_ACCESS;
			rd_cnt   <= LAST_CYC;
			poison   <= 1'h1;
		end else begin
			// Writes after the hold window leave the captured word alone.
			if (collide_late) begin
				poison <= 1'h1;
			end
			if (hold_cnt != '0) begin
				hold_cnt <= hold_cnt - LAST_CYC;
			end
			case (rd_state)
				RD_IDLE: begin
					rd_cnt <= '0;
				end
				RD_ACCESS: begin
					rd_cnt <= rd_cnt - LAST_CYC;
					if (rd_cnt == LAST_CYC) begin
						rd_state <= RD_IDLE;
					end
				end
				default: begin
					rd_state <= RD_IDLE;
				end
			endcase
		end
	end

	// The output keeps its old word until the access time has passed.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			read_data   <= '0;
			read_parity <= 1'h0;
		end else if (rd_present) begin
			read_data   <= poison ? {DATA_W{1'hX}} : rd_value;
			read_parity <= poison ? 1'hX : rd_value_parity;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	forward_write_a: assert property (
		start_sync & ~mode.write_async & same_addr
		|=> rd_value == $past(wr.write_data_in))
		else $error("same-cycle clocked write not forwarded");

	new_data_a: assert property (
		start_sync & async_wr & (wr.write_address == rd.read_address)
		|=> rd_value == $past(wr.write_data_in) && !poison)
		else $error("strobed write with read edge not seen");

	old_data_a: assert property (
		~mode.read_async & ~start_sync & rd_state == RD_ACCESS
		& hold_cnt == '0 & async_wr
		|=> rd_value == $past(rd_value) && poison == $past(poison))
		else $error("late strobed write disturbed held word");

	collide_unknown_a: assert property (
		collide_late & ~start_sync |=> poison)
		else $error("hold window collision not marked unknown");

	timing_pipe_a: assert property (
		start_sync & mode.read_pipelined
		|=> !rd_present ##1 !rd_present ##1 rd_present)
		else $error("pipelined read presented at wrong cycle");

	timing_access_a: assert property (
		start_sync & ~mode.read_pipelined
		|=> $stable(read_data) && !rd_present ##1 rd_present)
		else $error("access-timed read presented at wrong cycle");

	refresh_write_a: assert property (
		refresh & ~start_async & ~start_sync
		|=> rd_present && rd_value == $past(wr.write_data_in))
		else $error("write did not refresh strobed read");

	strobe_access_a: assert property (
		start_async |-> ##[1:STROBE_ACC] rd_present)
		else $error("strobed read not presented in time");

	stale_setup_a: assert property (
		start_async & stale |=> poison)
		else $error("read inside write edge window not marked");

	newer_hold_a: assert property (
		newer_lost & ~start_async & ~start_sync & ~refresh
		|=> poison && rd_present)
		else $error("read end inside write fall window not marked");

	capture_write_a: assert property (
		sync_wr |=> mem[$past(wr.write_address)]
		== $past(wr.write_data_in))
		else $error("clocked write not captured");

endmodule : two_port_ram

/* dv/fabric_user_logic.sv */
// Model of the fabric user logic that drives both memory ports.
// Assumes the bench calls its tasks just after a rising ref_clk edge and
// lets at least one edge pass between a go task and its matching end.
`timescale 1ns/1ps
module fabric_user_logic
	import ram_collision_pkg::*;
(
	// Clock
	input  wire logic  ref_clk,
	// Port drives
	output write_port_t wr,
	output read_port_t  rd
);
	initial begin
		wr = '1;
		wr.write_port_clock = CLOCK_IDLE;
		rd = '1;
		rd.read_port_clock = CLOCK_IDLE;
	end

	// This model never looks at the parity error flag at all.

	task automatic wr_go(input logic strobed, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic p);
		wr.write_address = a;
		wr.write_data_in = d;
		wr.write_parity_in = p;
		wr.write_block_select_n = 1'h0;
		if (strobed) begin
			wr.async_write_strobe_n = 1'h0;
		end else begin
			wr.write_enable_n = 1'h0;
			wr.write_port_clock = 1'h1;
		end
	endtask : wr_go

	// Released address, data and parity lines show the inverse of their last value, so a late
	// sample in the design picks up a wrong word instead of a lucky one.
	task automatic wr_end();
		wr.write_port_clock = CLOCK_IDLE;
		wr.write_enable_n = 1'h1;
		wr.write_block_select_n = 1'h1;
		wr.async_write_strobe_n = STROBE_IDLE;
		wr.write_address = ~wr.write_address;
		wr.write_data_in = ~wr.write_data_in;
		wr.write_parity_in = ~wr.write_parity_in;
	endtask : wr_end

	task automatic rd_go(input logic strobed, input logic [ADDR_W-1:0] a);
		rd.read_address = a;
		if (strobed) begin
			rd.async_read_strobe_n = 1'h0;
		end else begin
			rd.read_port_clock = 1'h1;
		end
	endtask : rd_go

	task automatic rd_clk_low();
		rd.read_port_clock = CLOCK_IDLE;
	endtask : rd_clk_low

	task automatic rd_stop();
		rd.async_read_strobe_n = STROBE_IDLE;
		rd.read_address = ~rd.read_address;
	endtask : rd_stop
endmodule : fabric_user_logic

/* dv/test_embedded_two_port_ram_collision.sv */
// Self-checking bench for the two-port memory with collision handling.
// Assumes the fabric model drives both ports and the design samples all
// port signals on ref_clk.
`timescale 1ns/1ps
module test_embedded_two_port_ram_collision
	import ram_collision_pkg::*;
;
	logic              ref_clk = 1'h0;
	logic              sys_rst = 1'h1;
	port_mode_t        mode = '0;
	write_port_t       wr;
	read_port_t        rd;
	logic [DATA_W-1:0] read_data;
	logic              read_parity;
	logic              write_parity_error;
	int                failures = 0;
	int                comparisons = 0;

	always #2.5 ref_clk = ~ref_clk;

	fabric_user_logic fabric_user_logic_inst (
		.ref_clk(ref_clk), .wr(wr), .rd(rd));

	two_port_ram two_port_ram_inst (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .mode(mode), .wr(wr),
		.rd(rd), .read_data(read_data), .read_parity(read_parity),
		.write_parity_error(write_parity_error));

	task automatic conclude();
		if (failures == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : conclude

	task automatic step(input int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : step

	task automatic chk(input string what, input logic [DATA_W-1:0] exp);
		comparisons++;
		if (read_data !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, read_data);
		end
	endtask : chk

	task automatic chk_flag(input string what, input logic exp, got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_flag

	task automatic wpulse(input logic s, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic p);
		fabric_user_logic_inst.wr_go(s, a, d, p);
		step();
		fabric_user_logic_inst.wr_end();
		step();
	endtask : wpulse

	task automatic rread(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] prev, d);
		fabric_user_logic_inst.rd_go(1'h0, a);
		step();
		fabric_user_logic_inst.rd_clk_low();
		step(1 + int'(mode.read_pipelined));
		chk("word before access", prev);
		step();
		chk("read word", d);
	endtask : rread

	task automatic t_clocked();
		wpulse(1'h0, 8'h31, 8'h3C, 1'h0);
		wpulse(1'h0, 8'h30, 8'hA5, 1'h0);
		rread(8'h31, 8'h00, 8'h3C);
		rread(8'h30, 8'h3C, 8'hA5);
		// A deselected write must leave the stored word alone.
		fabric_user_logic_inst.wr_go(1'h0, 8'h30, 8'hFF, 1'h0);
		fabric_user_logic_inst.wr.write_block_select_n = 1'h1;
		step();
		fabric_user_logic_inst.wr_end();
		step();
		rread(8'h31, 8'hA5, 8'h3C);
		rread(8'h30, 8'h3C, 8'hA5);
		mode.read_pipelined = 1'h1;
		rread(8'h31, 8'hA5, 8'h3C);
		mode.read_pipelined = 1'h0;
	endtask : t_clocked

	task automatic t_same_clk();
		fabric_user_logic_inst.rd_go(1'h0, 8'h40);
		fabric_user_logic_inst.wr_go(1'h0, 8'h40, 8'h77, 1'h0);
		step();
		fabric_user_logic_inst.rd_clk_low();
		fabric_user_logic_inst.wr_end();
		step(2);
		chk("same edge collision", 8'h77);
	endtask : t_same_clk

	task automatic t_parity();
		logic first;
		for (int g = 0; g < 2; g++) begin
			mode.parity_generation_enable = g[0];
			for (int p = 0; p < 2; p++) begin
				wpulse(1'h0, 8'h20, 8'h5A, p[0]);
				if (g == 0 && p == 0) begin
					first = write_parity_error;
				end else if (g == 0) begin
					chk_flag("parity flip", 1'h1, first ^ write_parity_error);
				end else begin
					chk_flag("parity error", 1'h0, write_parity_error);
				end
			end
		end
		mode.parity_generation_enable = 1'h0;
		// With generation off the stored parity is the incoming bit.
		wpulse(1'h0, 8'h20, 8'h5A, 1'h1);
		rread(8'h20, 8'h77, 8'h5A);
		chk_flag("read parity", 1'h1, read_parity);
	endtask : t_parity

	// The strobed write falls wdly cycles after the read clock edge.
	task automatic t_collide(input int pipe, input int wdly);
		logic [DATA_W-1:0] exp;
		mode.read_pipelined = pipe[0];
		mode.write_async = 1'h1;
		wpulse(1'h1, 8'h50, 8'h11, 1'h0);
		exp = (wdly == 0) ? 8'hEE : (wdly == 1) ? 8'hXX : 8'h11;
		fabric_user_logic_inst.rd_go(1'h0, 8'h50);
		for (int i = 0; i <= 2 + pipe; i++) begin
			if (i == wdly) fabric_user_logic_inst.wr_go(1'h1, 8'h50, 8'hEE, 1'h0);
			step();
			if (i == 0) fabric_user_logic_inst.rd_clk_low();
			if (i == wdly) fabric_user_logic_inst.wr_end();
		end
		chk("strobe collision", exp);
		mode = '0;
	endtask : t_collide

	task automatic t_strobe_read();
		mode.read_async = 1'h1;
		mode.write_async = 1'h1;
		wpulse(1'h1, 8'h60, 8'h21, 1'h0);
		fabric_user_logic_inst.rd_go(1'h1, 8'h60);
		step(3);
		chk("strobed read", 8'h21);
		wpulse(1'h1, 8'h60, 8'h24, 1'h0);
		chk("strobed write refresh", 8'h24);
		fabric_user_logic_inst.rd_stop();
		step();
		mode.write_async = 1'h0;
		fabric_user_logic_inst.rd_go(1'h1, 8'h60);
		step(3);
		chk("strobed reread", 8'h24);
		fabric_user_logic_inst.wr_go(1'h0, 8'h60, 8'h22, 1'h0);
		step();
		fabric_user_logic_inst.wr_end();
		step();
		chk("refreshed read", 8'h22);
		fabric_user_logic_inst.rd_stop();
		step(2);
		chk("early strobe rise", 8'hXX);
		fabric_user_logic_inst.wr_go(1'h0, 8'h60, 8'h23, 1'h0);
		step();
		fabric_user_logic_inst.wr_end();
		fabric_user_logic_inst.rd_go(1'h1, 8'h60);
		step(3);
		chk("early strobe fall", 8'hXX);
		fabric_user_logic_inst.rd_stop();
		step();
		mode = '0;
	endtask : t_strobe_read

	// The whole sequence needs about 108 cycles; this is ample.
	initial begin
		#20000;
		failures++;
		conclude();
	end

	initial begin
		step(16);
		sys_rst = 1'h0;
		step();
		chk("reset word", 8'h00);
		chk_flag("reset parity", 1'h0, read_parity);
		t_clocked();
		t_same_clk();
		t_parity();
		for (int p = 0; p < 2; p++) begin
			for (int w = 0; w < 3; w++) begin
				t_collide(p, w);
			end
		end
		t_strobe_read();
		conclude();
	end
endmodule : test_embedded_two_port_ram_collision
